// *** core/serr_regs.svh ***
`ifndef SERR_REGS_SVH
`define SERR_REGS_SVH
// reply codes
`define SERR_CODE_COMM 8'd21
`define SERR_CODE_TIMEOUT 8'd22
`define SERR_CODE_OVERFLOW 8'd23
`define SERR_CODE_UNKNOWN 8'd24
`define SERR_CODE_RANGE 8'd25
`define SERR_CODE_COND 8'd26
`define SERR_CODE_FORMAT 8'd27
`define SERR_CODE_TERM 8'd30
`define SERR_CODE_NONE 8'h00
// character index of the closing lf in each reply
`define SERR_IDX_ACK_LF 3'h2
`define SERR_IDX_ERR_LF 3'h6
// record number bounds
`define SERR_RECNO_FIRST 10'h001
`define SERR_RECNO_LAST 10'h3e7
// ascii characters
`define SERR_CH_G 8'h47
`define SERR_CH_E 8'h45
`define SERR_CH_R 8'h52
`define SERR_CH_CR 8'h0d
`define SERR_CH_LF 8'h0a
`define SERR_CH_ZERO 8'h30
// status codes
`define SERR_ST_NORMAL 3'h0
`define SERR_ST_OVERFLOW 3'h1
`define SERR_ST_NEGCALC 3'h2
`define SERR_ST_A_OVER 3'h3
`define SERR_ST_B_OVER 3'h4
`define SERR_ST_A_UNDER 3'h5
`define SERR_ST_B_UNDER 3'h6
// comparator codes
`define SERR_CMP_DASH 2'h0
`define SERR_CMP_IN 2'h1
`define SERR_CMP_LOW 2'h2
`define SERR_CMP_HIGH 2'h3
`endif

// *** core/serr_pkg.sv ***
package serr_pkg;
    typedef enum logic [2:0] {
        SERR_IDLE,
        SERR_SEND,
        SERR_WAIT
    } serr_state_t;
    typedef struct packed {
        serr_state_t state;
        logic [7:0] code;
        logic is_err;
        logic [2:0] idx;
        logic [7:0] ch;
        logic valid;
        logic busy;
    } serr_tx_t;
    typedef struct packed {
        logic header_due;
        logic [9:0] recno;
        logic rec_valid;
        logic rec_header;
        logic [9:0] rec_no;
        logic rec_ref;
        logic [2:0] rec_status;
        logic [1:0] rec_cmp;
        logic rec_page;
    } serr_prn_t;
endpackage

// *** core/serr_reply_tx.sv ***
`timescale 1ns/1ns
`include "serr_regs.svh"
// ============================================================
// reply serialiser: G or ERRnn, then cr lf
module serr_reply_tx
    import serr_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic start_in,
    input wire logic is_err_in,
    input wire logic [7:0] code_in,
    input wire logic ready_in,
    output logic [7:0] char_out,
    output logic char_valid_out,
    output logic busy_out
);
    serr_tx_t s_reg, s_next;

    // ascii digit of a two-digit code
    function automatic logic [7:0] digit(input logic [7:0] v, input logic tens);
        logic [7:0] q;
        q = v / 8'd10;
        digit = tens ? (`SERR_CH_ZERO + q) : (`SERR_CH_ZERO + (v - q * 8'd10));
    endfunction

    function automatic logic [7:0] pick(input serr_tx_t s);
        logic [7:0] c;
        c = `SERR_CH_LF;
        if (!s.is_err) begin
            unique case (s.idx)
                3'h0: c = `SERR_CH_G;
                3'h1: c = `SERR_CH_CR;
                default: c = `SERR_CH_LF;
            endcase
        end else begin
            unique case (s.idx)
                3'h0: c = `SERR_CH_E;
                3'h1, 3'h2: c = `SERR_CH_R;
                3'h3: c = digit(s.code, 1'b1);
                3'h4: c = digit(s.code, 1'b0);
                3'h5: c = `SERR_CH_CR;
                default: c = `SERR_CH_LF;
            endcase
        end
        pick = c;
    endfunction

    // one character every second cycle at most, each held until the line accepts it
    always_comb begin
        s_next = s_reg;
        unique case (s_reg.state)
            SERR_IDLE: begin
                if (start_in) begin
                    s_next.state = SERR_SEND;
                    s_next.code = code_in;
                    s_next.is_err = is_err_in;
                    s_next.idx = 3'h0;
                end
            end
            SERR_SEND: begin
                s_next.state = SERR_WAIT;
            end
            SERR_WAIT: begin
                if (ready_in) begin
                    if ((s_reg.is_err && s_reg.idx == `SERR_IDX_ERR_LF)
                        || (!s_reg.is_err && s_reg.idx == `SERR_IDX_ACK_LF)) begin
                        s_next.state = SERR_IDLE; // lf sent, reply done
                    end else begin
                        s_next.idx = s_reg.idx + 3'h1;
                        s_next.state = SERR_SEND;
                    end
                end
            end
            default: s_next.state = SERR_IDLE;
        endcase
        // outputs kept in the state so they leave from flops, cleared by reset
        s_next.ch = pick(s_next);
        s_next.valid = (s_next.state == SERR_WAIT);
        s_next.busy = (s_next.state != SERR_IDLE);
        if (srst_in) begin
            s_next = '0;
            s_next.state = SERR_IDLE;
        end
    end

    always_ff @(posedge clk_in) begin
        s_reg <= s_next;
    end

    assign char_out = s_reg.ch;
    assign char_valid_out = s_reg.valid;
    assign busy_out = s_reg.busy;
endmodule

// *** core/serr_print_rec.sv ***
`timescale 1ns/1ns
`include "serr_regs.svh"
// ============================================================
// print record builder: header, number, status and comparator codes
module serr_print_rec
    import serr_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic print_req_in,
    input wire logic cmp_changed_in,
    input wire logic deviation_display_in,
    input wire logic screen_page_two_in,
    input wire logic meas_overflow_in,
    input wire logic meas_negcalc_in,
    input wire logic sensor_a_over_in,
    input wire logic sensor_b_over_in,
    input wire logic sensor_a_under_in,
    input wire logic sensor_b_under_in,
    input wire logic cmp_active_in,
    input wire logic cmp_below_in,
    input wire logic cmp_above_in,
    output logic rec_valid_out,
    output logic rec_header_out,
    output logic [9:0] rec_no_out,
    output logic rec_ref_out,
    output logic [2:0] rec_status_out,
    output logic [1:0] rec_cmp_out,
    output logic rec_page_out
);
    serr_prn_t p_reg, p_next;

    // status priority: overflow first, sensor warnings last
    function automatic logic [2:0] status_code(input logic [5:0] f);
        if (f[0]) status_code = `SERR_ST_OVERFLOW;
        else if (f[1]) status_code = `SERR_ST_NEGCALC;
        else if (f[2]) status_code = `SERR_ST_A_OVER;
        else if (f[3]) status_code = `SERR_ST_B_OVER;
        else if (f[4]) status_code = `SERR_ST_A_UNDER;
        else if (f[5]) status_code = `SERR_ST_B_UNDER;
        else status_code = `SERR_ST_NORMAL;
    endfunction

    always_comb begin
        p_next = p_reg;
        p_next.rec_valid = 1'b0;
        // a setting change during a print still marks the next one
        if (cmp_changed_in) begin
            p_next.header_due = 1'b1;
        end
        if (print_req_in) begin
            p_next.rec_valid = 1'b1;
            p_next.rec_header = p_reg.header_due;
            p_next.header_due = cmp_changed_in;
            p_next.rec_no = p_reg.recno;
            p_next.recno = (p_reg.recno == `SERR_RECNO_LAST) ? `SERR_RECNO_FIRST
                : p_reg.recno + 10'h001;
            p_next.rec_ref = deviation_display_in;
            p_next.rec_status = status_code({sensor_b_under_in, sensor_a_under_in, sensor_b_over_in,
                sensor_a_over_in, meas_negcalc_in, meas_overflow_in});
            p_next.rec_cmp = !cmp_active_in ? `SERR_CMP_DASH : cmp_below_in ? `SERR_CMP_LOW
                : cmp_above_in ? `SERR_CMP_HIGH : `SERR_CMP_IN;
            p_next.rec_page = screen_page_two_in;
        end
        if (srst_in) begin
            p_next = '0;
            p_next.header_due = 1'b1;
            p_next.recno = `SERR_RECNO_FIRST;
        end
    end

    always_ff @(posedge clk_in) begin
        p_reg <= p_next;
    end

    assign rec_valid_out = p_reg.rec_valid;
    assign rec_header_out = p_reg.rec_header;
    assign rec_no_out = p_reg.rec_no;
    assign rec_ref_out = p_reg.rec_ref;
    assign rec_status_out = p_reg.rec_status;
    assign rec_cmp_out = p_reg.rec_cmp;
    assign rec_page_out = p_reg.rec_page;
endmodule

// *** core/serr_top.sv ***
// Summary of operation
// - with replies on, a bad command gets an error reply 21..30 instead
// - a good setting command gets G, only while replies are on
// - overrun, framing or parity fault gives reply 21
// - command reception time-out gives reply 22
// - command longer than the receive buffer gives reply 23
// - unknown command name gives reply 24
// - parameter beyond its limits gives reply 25
// - command conflicting with present state gives reply 26
// - misplaced comma or overlong field gives reply 27
// - host ends with cr lf; only one of them gives reply 30
// - header on first print after reset or after comparator change
// - record number starts at 1, wraps from 999 to 1
// - reference value printed only in deviation display
// - status field: normal, overflow, negative, sensor over or under codes
// - comparator field: dash when inactive, else in, low, high
// - one full record per print request
`timescale 1ns/1ns
`include "serr_regs.svh"
// ============================================================
// command verdict and printed record top
module serr_top
    import serr_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic reply_enable_in,
    input wire logic cmd_done_in,
    input wire logic setting_cmd_in,
    input wire logic fault_line_in,
    input wire logic fault_timeout_in,
    input wire logic fault_overflow_in,
    input wire logic fault_unknown_in,
    input wire logic fault_range_in,
    input wire logic fault_cond_in,
    input wire logic fault_format_in,
    input wire logic fault_term_in,
    input wire logic tx_ready_in,
    output logic [7:0] tx_char_out,
    output logic tx_valid_out,
    output logic reply_busy_out,
    output logic [7:0] last_code_out,
    input wire logic print_req_in,
    input wire logic cmp_changed_in,
    input wire logic deviation_display_in,
    input wire logic screen_page_two_in,
    input wire logic meas_overflow_in,
    input wire logic meas_negcalc_in,
    input wire logic sensor_a_over_in,
    input wire logic sensor_b_over_in,
    input wire logic sensor_a_under_in,
    input wire logic sensor_b_under_in,
    input wire logic cmp_active_in,
    input wire logic cmp_below_in,
    input wire logic cmp_above_in,
    output logic rec_valid_out,
    output logic rec_header_out,
    output logic [9:0] rec_no_out,
    output logic rec_ref_out,
    output logic [2:0] rec_status_out,
    output logic [1:0] rec_cmp_out,
    output logic rec_page_out
);
    typedef struct packed {
        logic start;
        logic is_err;
        logic [7:0] code;
        logic [7:0] last;
    } serr_ctl_t;

    serr_ctl_t c_reg, c_next;
    logic tx_busy;

    // ============================================================
    // fixed priority: line faults first, since later checks are meaningless
    function automatic logic [7:0] err_code(input logic [7:0] f);
        if (f[0]) err_code = `SERR_CODE_COMM;
        else if (f[1]) err_code = `SERR_CODE_TIMEOUT;
        else if (f[2]) err_code = `SERR_CODE_OVERFLOW;
        else if (f[7]) err_code = `SERR_CODE_TERM;
        else if (f[3]) err_code = `SERR_CODE_UNKNOWN;
        else if (f[6]) err_code = `SERR_CODE_FORMAT;
        else if (f[4]) err_code = `SERR_CODE_RANGE;
        else if (f[5]) err_code = `SERR_CODE_COND;
        else err_code = `SERR_CODE_NONE;
    endfunction

    // ============================================================
    // verdict per finished command; a command during a reply is dropped, so pause
    always_comb begin
        logic [7:0] faults;
        faults = {fault_term_in, fault_format_in, fault_cond_in, fault_range_in,
            fault_unknown_in, fault_overflow_in, fault_timeout_in, fault_line_in};
        c_next = c_reg;
        c_next.start = 1'b0;
        if (cmd_done_in && !tx_busy && !c_reg.start) begin
            c_next.last = err_code(faults);
            if (reply_enable_in && faults != 8'h00) begin
                c_next.start = 1'b1;
                c_next.is_err = 1'b1;
                c_next.code = err_code(faults);
            end else if (reply_enable_in && setting_cmd_in) begin
                c_next.start = 1'b1;
                c_next.is_err = 1'b0;
                c_next.code = `SERR_CODE_NONE;
            end
        end
        if (srst_in) begin
            c_next = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        c_reg <= c_next;
    end

    assign last_code_out = c_reg.last;

    // ============================================================
    // reply characters, each reply closed by cr lf
    serr_reply_tx u_tx (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .start_in(c_reg.start),
        .is_err_in(c_reg.is_err),
        .code_in(c_reg.code),
        .ready_in(tx_ready_in),
        .char_out(tx_char_out),
        .char_valid_out(tx_valid_out),
        .busy_out(tx_busy)
    );

    assign reply_busy_out = tx_busy;

    // ============================================================
    // printed record fields
    serr_print_rec u_prn (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .print_req_in(print_req_in),
        .cmp_changed_in(cmp_changed_in),
        .deviation_display_in(deviation_display_in),
        .screen_page_two_in(screen_page_two_in),
        .meas_overflow_in(meas_overflow_in),
        .meas_negcalc_in(meas_negcalc_in),
        .sensor_a_over_in(sensor_a_over_in),
        .sensor_b_over_in(sensor_b_over_in),
        .sensor_a_under_in(sensor_a_under_in),
        .sensor_b_under_in(sensor_b_under_in),
        .cmp_active_in(cmp_active_in),
        .cmp_below_in(cmp_below_in),
        .cmp_above_in(cmp_above_in),
        .rec_valid_out(rec_valid_out),
        .rec_header_out(rec_header_out),
        .rec_no_out(rec_no_out),
        .rec_ref_out(rec_ref_out),
        .rec_status_out(rec_status_out),
        .rec_cmp_out(rec_cmp_out),
        .rec_page_out(rec_page_out)
    );
endmodule

// *** testbench/serr_line_model.sv ***
`timescale 1ns/1ns
// ============================================================
// serial sink standing in for the host or the printer
module serr_line_model (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic slow_in,
    input wire logic [7:0] char_in,
    input wire logic valid_in,
    output logic ready_out
);
    logic [1:0] cnt;
    logic [7:0] rx_q[$];
    // slow mode takes one char in four, like a busy printer
    assign ready_out = !slow_in || cnt == 2'h2;
    // capture on the edge where valid meets ready
    always @(posedge clk_in) begin
        if (srst_in) begin
            cnt <= 2'h0;
        end else begin
            cnt <= cnt + 2'h1;
            if (valid_in && ready_out) begin
                rx_q.push_back(char_in);
            end
        end
    end
endmodule

// *** testbench/serr_top_sva.sv ***
`timescale 1ns/1ns
`include "serr_regs.svh"
// ============================================================
// checker on the top ports
module serr_top_sva (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic reply_enable_in,
    input wire logic cmd_done_in,
    input wire logic setting_cmd_in,
    input wire logic fault_line_in,
    input wire logic fault_timeout_in,
    input wire logic fault_overflow_in,
    input wire logic fault_unknown_in,
    input wire logic fault_range_in,
    input wire logic fault_cond_in,
    input wire logic fault_format_in,
    input wire logic fault_term_in,
    input wire logic tx_ready_in,
    input wire logic [7:0] tx_char_out,
    input wire logic tx_valid_out,
    input wire logic reply_busy_out,
    input wire logic [7:0] last_code_out,
    input wire logic print_req_in,
    input wire logic cmp_changed_in,
    input wire logic deviation_display_in,
    input wire logic screen_page_two_in,
    input wire logic meas_overflow_in,
    input wire logic meas_negcalc_in,
    input wire logic sensor_a_over_in,
    input wire logic sensor_b_over_in,
    input wire logic sensor_a_under_in,
    input wire logic sensor_b_under_in,
    input wire logic cmp_active_in,
    input wire logic cmp_below_in,
    input wire logic cmp_above_in,
    input wire logic rec_valid_out,
    input wire logic rec_header_out,
    input wire logic [9:0] rec_no_out,
    input wire logic rec_ref_out,
    input wire logic [2:0] rec_status_out,
    input wire logic [1:0] rec_cmp_out,
    input wire logic rec_page_out
);
    logic prev_cmd_reg, due_reg, seen_reg, acc;
    logic [9:0] last_no_reg, next_no;
    logic [7:0] exp_code;
    logic [2:0] exp_st;
    logic [1:0] exp_cmp;
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    // a command counts only with the reply path idle
    assign acc = cmd_done_in && !reply_busy_out && !prev_cmd_reg;
    assign exp_code = fault_line_in ? `SERR_CODE_COMM : fault_timeout_in ? `SERR_CODE_TIMEOUT :
        fault_overflow_in ? `SERR_CODE_OVERFLOW : fault_term_in ? `SERR_CODE_TERM :
        fault_unknown_in ? `SERR_CODE_UNKNOWN : fault_format_in ? `SERR_CODE_FORMAT :
        fault_range_in ? `SERR_CODE_RANGE : fault_cond_in ? `SERR_CODE_COND : 8'h00;
    assign exp_st = meas_overflow_in ? 3'h1 : meas_negcalc_in ? 3'h2 : sensor_a_over_in ? 3'h3 :
        sensor_b_over_in ? 3'h4 : sensor_a_under_in ? 3'h5 : sensor_b_under_in ? 3'h6 : 3'h0;
    assign exp_cmp = !cmp_active_in ? 2'h0 : cmp_below_in ? 2'h2 : cmp_above_in ? 2'h3 : 2'h1;
    assign next_no = (!seen_reg || last_no_reg == 10'h3e7) ? 10'h001 : last_no_reg + 10'h001;
    // header owed after reset and after a comparator change
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            prev_cmd_reg <= 1'b0;
            due_reg <= 1'b1;
            seen_reg <= 1'b0;
            last_no_reg <= 10'h000;
        end else begin
            prev_cmd_reg <= cmd_done_in;
            due_reg <= cmp_changed_in || (due_reg && !print_req_in);
            if (rec_valid_out) begin
                seen_reg <= 1'b1;
                last_no_reg <= rec_no_out;
            end
        end
    end
    a_code_pick: assert property (acc && reply_enable_in |=> last_code_out == $past(exp_code))
        else $error("reply code not by priority");
    a_err_reply: assert property (acc && reply_enable_in && exp_code != 8'h00
        |-> ##[2:4] tx_valid_out && tx_char_out == `SERR_CH_E) else $error("error reply missing");
    a_ack_reply: assert property (acc && reply_enable_in && exp_code == 8'h00 && setting_cmd_in
        |-> ##[2:4] tx_valid_out && tx_char_out == `SERR_CH_G) else $error("ack missing");
    a_no_reply: assert property (acc && (!reply_enable_in || (exp_code == 8'h00 && !setting_cmd_in))
        |=> (!reply_busy_out && !tx_valid_out) [*4]) else $error("reply sent when none due");
    a_char_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_char_out))
        else $error("char dropped before accept");
    a_rec_pulse: assert property (1'b1 |=> rec_valid_out == $past(print_req_in))
        else $error("record pulse wrong");
    a_rec_number: assert property (rec_valid_out |-> rec_no_out == next_no)
        else $error("record number wrong");
    a_header_due: assert property (print_req_in |=> rec_header_out == $past(due_reg))
        else $error("header flag wrong");
    a_rec_codes: assert property (print_req_in |=> rec_status_out == $past(exp_st)
        && rec_cmp_out == $past(exp_cmp)) else $error("record codes wrong");
    a_ref_page: assert property (print_req_in |=> rec_ref_out == $past(deviation_display_in)
        && rec_page_out == $past(screen_page_two_in)) else $error("ref or page wrong");
    c_err: cover property (acc && reply_enable_in && exp_code != 8'h00);
    c_ack: cover property (acc && reply_enable_in && setting_cmd_in && exp_code == 8'h00);
    c_wrap: cover property (rec_valid_out && rec_no_out == 10'h001 && seen_reg);
endmodule

// *** testbench/serr_top_tb.sv ***
`timescale 1ns/1ns
`include "serr_regs.svh"
// ============================================================
// bench: reply sequences and printed records
module serr_top_tb;
    logic clk_in, srst_in, reply_enable_in, cmd_done_in, setting_cmd_in, tx_ready_in, slow, due;
    logic fault_line_in, fault_timeout_in, fault_overflow_in, fault_unknown_in;
    logic fault_range_in, fault_cond_in, fault_format_in, fault_term_in;
    logic print_req_in, cmp_changed_in, deviation_display_in, screen_page_two_in;
    logic meas_overflow_in, meas_negcalc_in, sensor_a_over_in, sensor_b_over_in;
    logic sensor_a_under_in, sensor_b_under_in, cmp_active_in, cmp_below_in, cmp_above_in;
    logic [7:0] tx_char_out, last_code_out;
    logic tx_valid_out, reply_busy_out, rec_valid_out, rec_header_out, rec_ref_out, rec_page_out;
    logic [9:0] rec_no_out;
    logic [2:0] rec_status_out;
    logic [1:0] rec_cmp_out;
    logic [7:0] codes[8] = '{8'd21, 8'd22, 8'd23, 8'd24, 8'd25, 8'd26, 8'd27, 8'd30};
    int n_fail = 0, n_tests = 0, cyc = 0, exp_no = 0, s, m;
    serr_top i_serr_top (.*);
    serr_line_model i_serr_line_model (.clk_in, .srst_in, .slow_in(slow), .char_in(tx_char_out),
        .valid_in(tx_valid_out), .ready_out(tx_ready_in));
    // ============================================================
    // helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one command verdict, then the whole reply collected at the line
    task automatic cmd(input logic en, input logic set, input logic [7:0] f, input logic [7:0] code);
        logic [7:0] q[$];
        int i;
        i_serr_line_model.rx_q = {};
        @(posedge clk_in);
        reply_enable_in <= en;
        setting_cmd_in <= set;
        {fault_line_in, fault_timeout_in, fault_overflow_in, fault_unknown_in} <= f[7:4];
        {fault_range_in, fault_cond_in, fault_format_in, fault_term_in} <= f[3:0];
        cmd_done_in <= 1'b1;
        @(posedge clk_in);
        cmd_done_in <= 1'b0;
        i = 0;
        // host waits for the reply to end before the next command
        while ((i < 4 || reply_busy_out) && i < 300) begin
            @(posedge clk_in);
            i++;
        end
        check("reply done", i < 300, 1'b1);
        if (code != 8'h00) begin
            q = {`SERR_CH_E, `SERR_CH_R, `SERR_CH_R, `SERR_CH_ZERO + code / 10, `SERR_CH_ZERO + code % 10,
                `SERR_CH_CR, `SERR_CH_LF};
        end else if (set) begin
            q = {`SERR_CH_G, `SERR_CH_CR, `SERR_CH_LF};
        end
        if (!en) begin
            q = {};
        end
        check("reply length", i_serr_line_model.rx_q.size(), q.size());
        foreach (q[k]) check("reply char", i_serr_line_model.rx_q[k], q[k]);
        if (en) check("last code", last_code_out, code);
    endtask
    task automatic prn(input logic [10:0] c, input logic [2:0] st, input logic [1:0] cm);
        @(posedge clk_in);
        {deviation_display_in, screen_page_two_in, meas_overflow_in, meas_negcalc_in, sensor_a_over_in,
            sensor_b_over_in, sensor_a_under_in, sensor_b_under_in, cmp_active_in, cmp_below_in, cmp_above_in} <= c;
        print_req_in <= 1'b1;
        @(posedge clk_in);
        print_req_in <= 1'b0;
        #1;
        exp_no = (exp_no == 999) ? 1 : exp_no + 1;
        check("rec valid", rec_valid_out, 1'b1);
        check("rec header", rec_header_out, due);
        due = 1'b0;
        check("rec no", rec_no_out, exp_no[9:0]);
        check("rec ref", rec_ref_out, c[10]);
        check("rec page", rec_page_out, c[9]);
        check("rec status", rec_status_out, st);
        check("rec cmp", rec_cmp_out, cm);
    endtask
    // ============================================================
    // clock and hang guard
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    // ============================================================
    // main sequence
    initial begin
        {reply_enable_in, cmd_done_in, setting_cmd_in, print_req_in, cmp_changed_in, slow} = '0;
        {fault_line_in, fault_timeout_in, fault_overflow_in, fault_unknown_in} = '0;
        {fault_range_in, fault_cond_in, fault_format_in, fault_term_in} = '0;
        {deviation_display_in, screen_page_two_in, meas_overflow_in, meas_negcalc_in, sensor_a_over_in,
            sensor_b_over_in, sensor_a_under_in, sensor_b_under_in, cmp_active_in, cmp_below_in, cmp_above_in} = '0;
        due = 1'b1;
        srst_in = 1'b1;
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        // each fault alone, host fast and slow in turn
        for (int i = 0; i < 8; i++) begin
            slow <= i[0];
            cmd(1'b1, 1'b1, 8'h80 >> i, codes[i]);
        end
        cmd(1'b1, 1'b1, 8'hff, 8'd21);
        cmd(1'b1, 1'b0, 8'h1f, 8'd30);
        cmd(1'b1, 1'b0, 8'h1e, 8'd24);
        cmd(1'b1, 1'b0, 8'h0e, 8'd27);
        cmd(1'b1, 1'b0, 8'h0c, 8'd25);
        cmd(1'b1, 1'b1, 8'h00, 8'h00);
        cmd(1'b1, 1'b0, 8'h00, 8'h00);
        cmd(1'b0, 1'b1, 8'h00, 8'h00);
        cmd(1'b0, 1'b0, 8'h08, 8'd25);
        // records through the number wrap, every status and comparator case
        for (int k = 0; k < 1002; k++) begin
            s = k % 7;
            m = k % 4;
            if (k == 500) begin
                @(posedge clk_in);
                cmp_changed_in <= 1'b1;
                @(posedge clk_in);
                cmp_changed_in <= 1'b0;
                due = 1'b1;
            end
            prn({k[0], k[1], (s == 0) ? 6'h00 : 6'h20 >> (s - 1),
                (m == 0) ? 3'h2 : (m == 1) ? 3'h4 : (m == 2) ? 3'h7 : 3'h5}, s[2:0], m[1:0]);
        end
        prn({2'h0, 6'h3f, 3'h7}, 3'h1, 2'h2);
        // reset in mid-run: outputs clear, numbering and header start over
        @(posedge clk_in);
        srst_in <= 1'b1;
        @(posedge clk_in);
        srst_in <= 1'b0;
        #1;
        check("reset outputs", {tx_valid_out, reply_busy_out, last_code_out}, 10'h000);
        exp_no = 0;
        due = 1'b1;
        prn(11'h002, 3'h0, 2'h0);
        finish_test();
    end
endmodule
bind serr_top serr_top_sva i_serr_top_sva (.*);
